/* src/cssc_pkg.sv */
package cssc_pkg;

    // ****************************************
    // Register bus geometry
    // ****************************************
    localparam int          CSSC_ADDR_W      = 8;
    localparam int          CSSC_DATA_W      = 16;
    localparam int          CSSC_CHAN_N      = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0]  CSSC_CTRL_OFF    = 8'h09;
    localparam logic [7:0]  CSSC_RESULT_OFF  = 8'h10;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] CSSC_CTRL_RST    = 16'h0000;
    localparam logic [15:0] CSSC_RESULT_RST  = 16'h0000;
    localparam logic [15:0] CSSC_RDATA_RST   = 16'h0000;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int          CSSC_SHUNT_A_GO_BIT   = 14;
    localparam int          CSSC_SHUNT_B_GO_BIT   = 12;
    localparam int          CSSC_SHUNT_A_HALT_BIT = 10;
    localparam int          CSSC_SHUNT_B_HALT_BIT = 8;
    localparam int          CSSC_SEQ_GO_BIT       = 6;
    localparam int          CSSC_SEQ_HALT_BIT     = 2;

    // ****************************************
    // Channel indices
    // ****************************************
    localparam int          CSSC_CH_A        = 0;
    localparam int          CSSC_CH_B        = 1;
    localparam int          CSSC_CH_SEQ      = 2;

endpackage

/* src/cssc_conv_ctrl.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module cssc_conv_ctrl
    import cssc_pkg::*;
#(
    parameter int ADDR_W = CSSC_ADDR_W,
    parameter int DATA_W = CSSC_DATA_W
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    // Shunt converter A
    input  wire logic              shunt_a_enable_in,
    input  wire logic              shunt_a_single_in,
    input  wire logic              shunt_a_done_in,
    output logic                   shunt_a_go_out,
    output logic                   shunt_a_stop_out,
    // Shunt converter B
    input  wire logic              shunt_b_enable_in,
    input  wire logic              shunt_b_single_in,
    input  wire logic              shunt_b_done_in,
    output logic                   shunt_b_go_out,
    output logic                   shunt_b_stop_out,
    // Muxed converter sequence
    input  wire logic              sequence_done_in,
    output logic                   sequence_go_out,
    output logic                   sequence_stop_out,
    // Step 0 result capture
    input  wire logic              step0_valid_in,
    input  wire logic [DATA_W-1:0] step0_data_in
);

    // ****************************************
    // Channel gathering
    // ****************************************
    logic [CSSC_CHAN_N-1:0] chan_en;
    logic [CSSC_CHAN_N-1:0] chan_single;
    logic [CSSC_CHAN_N-1:0] chan_done;
    logic [CSSC_CHAN_N-1:0] go_bit;
    logic [CSSC_CHAN_N-1:0] halt_bit;
    logic [CSSC_CHAN_N-1:0] go_r;
    logic [CSSC_CHAN_N-1:0] stop_r;
    logic [CSSC_CHAN_N-1:0] halt_r;
    logic [DATA_W-1:0]      result_r;
    logic [DATA_W-1:0]      rdata_r;
    logic [DATA_W-1:0]      ctrl_view;
    logic                   ctrl_wr;

    assign ctrl_wr                 = reg_wr_in && (reg_addr_in == CSSC_CTRL_OFF);

    assign chan_en[CSSC_CH_A]      = shunt_a_enable_in;
    assign chan_en[CSSC_CH_B]      = shunt_b_enable_in;
    assign chan_en[CSSC_CH_SEQ]    = 1'b1;
    assign chan_single[CSSC_CH_A]  = shunt_a_single_in;
    assign chan_single[CSSC_CH_B]  = shunt_b_single_in;
    assign chan_single[CSSC_CH_SEQ] = 1'b0;
    assign chan_done[CSSC_CH_A]    = shunt_a_done_in;
    assign chan_done[CSSC_CH_B]    = shunt_b_done_in;
    assign chan_done[CSSC_CH_SEQ]  = sequence_done_in;

    // Whole write frame is decoded at once
    assign go_bit[CSSC_CH_A]       = reg_wdata_in[CSSC_SHUNT_A_GO_BIT];
    assign go_bit[CSSC_CH_B]       = reg_wdata_in[CSSC_SHUNT_B_GO_BIT];
    assign go_bit[CSSC_CH_SEQ]     = reg_wdata_in[CSSC_SEQ_GO_BIT];
    assign halt_bit[CSSC_CH_A]     = reg_wdata_in[CSSC_SHUNT_A_HALT_BIT];
    assign halt_bit[CSSC_CH_B]     = reg_wdata_in[CSSC_SHUNT_B_HALT_BIT];
    assign halt_bit[CSSC_CH_SEQ]   = reg_wdata_in[CSSC_SEQ_HALT_BIT];

    assign shunt_a_go_out          = go_r[CSSC_CH_A];
    assign shunt_b_go_out          = go_r[CSSC_CH_B];
    assign sequence_go_out         = go_r[CSSC_CH_SEQ];
    assign shunt_a_stop_out        = stop_r[CSSC_CH_A];
    assign shunt_b_stop_out        = stop_r[CSSC_CH_B];
    assign sequence_stop_out       = stop_r[CSSC_CH_SEQ];
    assign reg_rdata_out           = rdata_r;

    // ****************************************
    // Per-channel start and stop control
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < CSSC_CHAN_N; ch = ch + 1) begin : g_chan

            // Start pulse, also aborts an ongoing conversion or sequence
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    go_r[ch] <= 1'b0;
                end else begin
                    go_r[ch] <= ctrl_wr && go_bit[ch] && chan_en[ch];
                end
            end

            // Pending stop; start clears it, new request beats completion
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    halt_r[ch] <= 1'b0;
                end else if (ctrl_wr && go_bit[ch]) begin
                    halt_r[ch] <= 1'b0;
                end else if (ctrl_wr && halt_bit[ch] && !chan_single[ch]) begin
                    halt_r[ch] <= 1'b1;
                end else if (chan_done[ch]) begin
                    halt_r[ch] <= 1'b0;
                end
            end

            // Stop takes effect only when the running work completes
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    stop_r[ch] <= 1'b0;
                end else begin
                    stop_r[ch] <= chan_done[ch] && halt_r[ch] && !(ctrl_wr && go_bit[ch]);
                end
            end

            // ****************************************
            // Channel checks
            // ****************************************
            sequence s_start_write;
                ctrl_wr && go_bit[ch];
            endsequence

            sequence s_halt_done;
                halt_r[ch] && chan_done[ch] && !ctrl_wr;
            endsequence

            property p_go_pulse;
                @(posedge clk_in) disable iff (sys_rst_in)
                s_start_write and chan_en[ch] |=> go_r[ch] ##1 !go_r[ch] || $past(ctrl_wr && go_bit[ch]);
            endproperty
            a_go_pulse: assert property (p_go_pulse)
                else $error("Start pulse missing");

            property p_go_cause;
                @(posedge clk_in) disable iff (sys_rst_in)
                go_r[ch] |-> $past(ctrl_wr) && $past(go_bit[ch]) && $past(chan_en[ch]);
            endproperty
            a_go_cause: assert property (p_go_cause)
                else $error("Start pulse without start write");

            property p_start_beats_stop;
                @(posedge clk_in) disable iff (sys_rst_in)
                s_start_write |=> !halt_r[ch] && !stop_r[ch];
            endproperty
            a_start_beats_stop: assert property (p_start_beats_stop)
                else $error("Stop survived a start in the same frame");

            property p_halt_set;
                @(posedge clk_in) disable iff (sys_rst_in)
                ctrl_wr && halt_bit[ch] && !go_bit[ch] && !chan_single[ch] |=> halt_r[ch];
            endproperty
            a_halt_set: assert property (p_halt_set)
                else $error("Stop request not held");

            property p_single_ignored;
                @(posedge clk_in) disable iff (sys_rst_in)
                ctrl_wr && halt_bit[ch] && chan_single[ch] && !halt_r[ch] |=> !halt_r[ch];
            endproperty
            a_single_ignored: assert property (p_single_ignored)
                else $error("Stop accepted in single-shot mode");

            property p_halt_clear;
                @(posedge clk_in) disable iff (sys_rst_in)
                s_halt_done |=> !halt_r[ch] && stop_r[ch] ##1 !stop_r[ch];
            endproperty
            a_halt_clear: assert property (p_halt_clear)
                else $error("Stop not cleared at completion");

            property p_halt_holds;
                @(posedge clk_in) disable iff (sys_rst_in)
                halt_r[ch] && !chan_done[ch] && !(ctrl_wr && go_bit[ch]) |=> halt_r[ch];
            endproperty
            a_halt_holds: assert property (p_halt_holds)
                else $error("Pending stop dropped early");

            property p_halt_cause;
                @(posedge clk_in) disable iff (sys_rst_in)
                $rose(halt_r[ch]) |-> $past(ctrl_wr && halt_bit[ch] && !go_bit[ch] && !chan_single[ch]);
            endproperty
            a_halt_cause: assert property (p_halt_cause)
                else $error("Stop pending without stop write");

            property p_stop_cause;
                @(posedge clk_in) disable iff (sys_rst_in)
                stop_r[ch] |-> $past(chan_done[ch]) && $past(halt_r[ch]) && !$past(ctrl_wr && go_bit[ch]);
            endproperty
            a_stop_cause: assert property (p_stop_cause)
                else $error("Stop issued before work completed");

            property p_go_gated;
                @(posedge clk_in) disable iff (sys_rst_in)
                s_start_write and !chan_en[ch] |=> !go_r[ch];
            endproperty
            a_go_gated: assert property (p_go_gated)
                else $error("Start pulse for disabled converter");

            property p_stop_single;
                @(posedge clk_in) disable iff (sys_rst_in)
                chan_single[ch] && !halt_r[ch] |=> !stop_r[ch];
            endproperty
            a_stop_single: assert property (p_stop_single)
                else $error("Stop issued in single-shot mode");

            property p_halt_other_write;
                @(posedge clk_in) disable iff (sys_rst_in)
                reg_wr_in && (reg_addr_in != CSSC_CTRL_OFF) && !chan_done[ch] |=> $stable(halt_r[ch]);
            endproperty
            a_halt_other_write: assert property (p_halt_other_write)
                else $error("Stop pending changed by other register write");
        end
    endgenerate

    // ****************************************
    // Step 0 result register
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            result_r <= CSSC_RESULT_RST;
        end else if (step0_valid_in) begin
            result_r <= step0_data_in;
        end
    end

    // ****************************************
    // Result checks
    // ****************************************
    property p_result_load;
        @(posedge clk_in) disable iff (sys_rst_in)
        step0_valid_in |=> result_r == $past(step0_data_in);
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("Step 0 result not captured");

    property p_result_hold;
        @(posedge clk_in) disable iff (sys_rst_in)
        !step0_valid_in |=> $stable(result_r);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("Step 0 result changed without new data");

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        ctrl_view                        = CSSC_CTRL_RST;
        ctrl_view[CSSC_SHUNT_A_HALT_BIT] = halt_r[CSSC_CH_A];
        ctrl_view[CSSC_SHUNT_B_HALT_BIT] = halt_r[CSSC_CH_B];
        ctrl_view[CSSC_SEQ_HALT_BIT]     = halt_r[CSSC_CH_SEQ];
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_r <= CSSC_RDATA_RST;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                CSSC_CTRL_OFF: begin
                    rdata_r <= ctrl_view;
                end
                CSSC_RESULT_OFF: begin
                    rdata_r <= result_r;
                end
                default: begin
                    rdata_r <= CSSC_RDATA_RST;
                end
            endcase
        end else begin
            rdata_r <= CSSC_RDATA_RST;
        end
    end

    // ****************************************
    // Register checks
    // ****************************************
    property p_start_reads_zero;
        @(posedge clk_in) disable iff (sys_rst_in)
        reg_rd_in && (reg_addr_in == CSSC_CTRL_OFF) |=>
            !reg_rdata_out[CSSC_SHUNT_A_GO_BIT] && !reg_rdata_out[CSSC_SHUNT_B_GO_BIT]
            && !reg_rdata_out[CSSC_SEQ_GO_BIT];
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero)
        else $error("Start bit read back as one");

    property p_halt_readback;
        @(posedge clk_in) disable iff (sys_rst_in)
        reg_rd_in && (reg_addr_in == CSSC_CTRL_OFF) |=>
            reg_rdata_out[CSSC_SHUNT_A_HALT_BIT] == $past(halt_r[CSSC_CH_A])
            && reg_rdata_out[CSSC_SHUNT_B_HALT_BIT] == $past(halt_r[CSSC_CH_B])
            && reg_rdata_out[CSSC_SEQ_HALT_BIT] == $past(halt_r[CSSC_CH_SEQ]);
    endproperty
    a_halt_readback: assert property (p_halt_readback)
        else $error("Stop bit readback wrong");

    sequence s_result_load;
        step0_valid_in ##1 reg_rd_in && (reg_addr_in == CSSC_RESULT_OFF) && !step0_valid_in;
    endsequence

    property p_result_read;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_result_load |=> reg_rdata_out == $past(step0_data_in, 2);
    endproperty
    a_result_read: assert property (p_result_read)
        else $error("Step 0 result readback wrong");

    property p_result_ro;
        @(posedge clk_in) disable iff (sys_rst_in)
        reg_wr_in && (reg_addr_in == CSSC_RESULT_OFF) && !step0_valid_in |=> $stable(result_r);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("Result register changed by a write");

    property p_rdata_idle;
        @(posedge clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> reg_rdata_out == CSSC_RDATA_RST;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data outside read answer");

    property p_unmapped_read;
        @(posedge clk_in) disable iff (sys_rst_in)
        reg_rd_in && (reg_addr_in != CSSC_CTRL_OFF) && (reg_addr_in != CSSC_RESULT_OFF) |=> reg_rdata_out == CSSC_RDATA_RST;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped read returned data");

endmodule

/* tb/cssc_conv_model.sv */
`timescale 1ns/1ps
module cssc_conv_model #(
    parameter int PERIOD = 16
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Commands from the control block
    input  wire logic [2:0] go_in,
    input  wire logic [2:0] stop_in,
    // Conversion finished pulses
    output logic      [2:0] done_out
);
    // ****************************************
    // Converters started by go and halted by stop, one per channel
    // ****************************************
    logic [2:0] run_r;
    logic [7:0] cnt_r [3];

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 3; i++) begin
            done_out[i] <= 1'b0;
            if (sys_rst_in) begin
                run_r[i] <= 1'b0;
                cnt_r[i] <= 8'h00;
            end else if (go_in[i]) begin
                run_r[i] <= 1'b1;
                cnt_r[i] <= 8'h00;
            end else if (stop_in[i]) begin
                run_r[i] <= 1'b0;
            end else if (run_r[i]) begin
                if (cnt_r[i] == 8'(PERIOD - 1)) begin
                    cnt_r[i]    <= 8'h00;
                    done_out[i] <= 1'b1;
                end else begin
                    cnt_r[i] <= cnt_r[i] + 8'h01;
                end
            end
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import cssc_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        en_a = 1'b1;
    logic        en_b = 1'b1;
    logic        sg_a = 1'b0;
    logic        sg_b = 1'b0;
    logic        s0_valid = 1'b0;
    logic [15:0] s0_data = 16'h0000;
    logic [2:0]  go_vec;
    logic [2:0]  stop_vec;
    logic [2:0]  done_vec;
    int          miscompares = 0;
    int          num_checks = 0;
    logic [15:0] go_m [3] = '{16'h4000, 16'h1000, 16'h0040};
    logic [15:0] halt_m [3] = '{16'h0400, 16'h0100, 16'h0004};

    always #10 clk_in = ~clk_in;

    cssc_conv_ctrl dut_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .shunt_a_enable_in(en_a), .shunt_a_single_in(sg_a), .shunt_a_done_in(done_vec[0]),
        .shunt_a_go_out(go_vec[0]), .shunt_a_stop_out(stop_vec[0]),
        .shunt_b_enable_in(en_b), .shunt_b_single_in(sg_b), .shunt_b_done_in(done_vec[1]),
        .shunt_b_go_out(go_vec[1]), .shunt_b_stop_out(stop_vec[1]),
        .sequence_done_in(done_vec[2]), .sequence_go_out(go_vec[2]), .sequence_stop_out(stop_vec[2]),
        .step0_valid_in(s0_valid), .step0_data_in(s0_data)
    );

    cssc_conv_model model_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go_vec), .stop_in(stop_vec), .done_out(done_vec)
    );

    // ****************************************
    // Bus, stop-wait and verdict tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    task automatic wait_stop(input int i);
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_in);
            #1;
            if (stop_vec[i] === 1'b1) break;
        end
        if (n == 60) begin
            miscompares++;
            give_verdict();
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        reg_read(CSSC_CTRL_OFF, 16'h0000);
        reg_read(CSSC_RESULT_OFF, 16'h0000);
        reg_read(8'h0a, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            reg_write(CSSC_CTRL_OFF, go_m[i]);
            `CHK(go_vec, 3'(1 << i))
            reg_read(CSSC_CTRL_OFF, 16'h0000);
            reg_write(CSSC_CTRL_OFF, halt_m[i]);
            reg_read(CSSC_CTRL_OFF, halt_m[i]);
            wait_stop(i);
            reg_read(CSSC_CTRL_OFF, 16'h0000);
            reg_write(CSSC_CTRL_OFF, go_m[i] | halt_m[i]);
            `CHK(go_vec, 3'(1 << i))
            reg_read(CSSC_CTRL_OFF, 16'h0000);
            reg_write(CSSC_CTRL_OFF, halt_m[i]);
            reg_write(CSSC_CTRL_OFF, go_m[i]);
            `CHK(go_vec, 3'(1 << i))
            reg_read(CSSC_CTRL_OFF, 16'h0000);
        end
        @(posedge clk_in);
        sg_a <= 1'b1;
        sg_b <= 1'b1;
        en_a <= 1'b0;
        en_b <= 1'b0;
        reg_write(CSSC_CTRL_OFF, 16'h0500);
        reg_read(CSSC_CTRL_OFF, 16'h0000);
        reg_write(CSSC_CTRL_OFF, 16'h5000);
        `CHK(go_vec, 3'b000)
        @(posedge clk_in);
        s0_valid <= 1'b1;
        s0_data  <= 16'h8001;
        @(posedge clk_in);
        s0_valid <= 1'b0;
        addr     <= CSSC_RESULT_OFF;
        rd       <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 16'h8001)
        reg_write(CSSC_RESULT_OFF, 16'h1234);
        reg_read(CSSC_RESULT_OFF, 16'h8001);
        give_verdict();
    end
endmodule
